//--- include/sip_defs.svh
// constants for the ingress policing and snoop stage
`ifndef SIP_DEFS_SVH
`define SIP_DEFS_SVH
`define SIP_NPORT           3
`define SIP_NPRI            8
`define SIP_NSTREAM         24
`define SIP_BUCKET_INIT     17'h00600
`define SIP_CIR_STEP_NS     20
`define SIP_CIR_MIN_NS      80
`define SIP_CIR_MIN_SET     14'h0003
`define SIP_CLK_NS          100
`define SIP_THROT_NS        1720000
`define SIP_THROT_CYC       (`SIP_THROT_NS / `SIP_CLK_NS)
`define SIP_THROT_UNIT      6
`define SIP_PROTO_GROUP     8'h02
`define SIP_NEXTHDR_LISTEN  8'h3A
`define SIP_VID_RESERVED    12'hFFF
`define SIP_VID_PRIO        12'h000
`define SIP_STP_FORWARD     2'h0
`define SIP_MODE_PORT       2'h0
`define SIP_MODE_PRI        2'h1
`define SIP_PRISEL_PREC     2'h0
`define SIP_PRISEL_DS       2'h1
`define SIP_PRISEL_VLAN     2'h2
`endif

//--- include/sip_pkg.sv
// types for the ingress policing and snoop stage
package sip_pkg;
  typedef enum logic [1:0] {
    SIP_GREEN  = 2'h0,
    SIP_YELLOW = 2'h1,
    SIP_RED    = 2'h2,
    SIP_NONE   = 2'h3
  } sip_color_e;
endpackage

//--- hw/sip_ingress_policer.sv
// ingress meter, broadcast throttle, flood limit and group snoop trap
// Functional notes
// RULE1: colour green within committed burst, yellow within excess burst, else red.
// RULE2: metering only while the ingress rate enable is set; else no streams.
// RULE3: rate mode picks per port (3), per priority (8) or port and priority (24).
// RULE4: each stream has its own rate; burst limits are shared by all streams.
// RULE5: at stream rate fill committed bucket first, then excess bucket, to maxima.
// RULE6: rate is time per byte; settings 0-3 give 80 ns, each step adds 20 ns.
// RULE7: enough committed tokens: debit committed bucket by length, colour green.
// RULE8: else enough excess tokens: debit excess, colour yellow, mark for random discard.
// RULE9: neither bucket enough: colour red and discard.
// RULE10: buckets start at 1536; lower limits cap only after draining below them.
// RULE11: priority from precedence, ds map, vlan priority or port default, no regeneration.
// RULE12: enabled port gets setting times 64 broadcast bytes per 1.72 ms, excess dropped.
// RULE13: flood traffic buffer count capped at the programmed flood buffer limit.
// RULE14: group management is ipv4 protocol 2, any framing, tagged or not.
// RULE15: listener packet is ipv6 with next header 58.
// RULE16: with snoop enabled, such packets are trapped to the snoop port only.
// RULE17: never back to source port unless snooped and reflect enabled.
// RULE18: snooped packet filtered when source not forwarding, unless override.
// RULE19: vlans on, untagged or priority tagged, admit-only-tagged port: filtered.
// RULE20: vlans on, tagged with vid FFF: filtered.
// RULE21: vlans on, membership check on, no non-member admission, not member: filtered.
// RULE22: host software adds the group to the address table and forwards the original.
// RULE23: port state 00 is forwarding.
// RULE24: ds map index is the top six bits of tos or traffic class.
// RULE25: per port and priority stream index is port times eight plus priority.
`timescale 1ns/1ns
`include "sip_defs.svh"

module sip_ingress_policer
  import sip_pkg::*;
#(
  parameter int CIR_W      = 14,
  parameter int TOK_W      = 17,
  parameter int BUF_W      = 10,
  parameter int THROT_CYC  = `SIP_THROT_CYC
)(
  input  wire logic                 clk,
  input  wire logic                 resetn,
  // ingress_meter_config / command / write data, as plain ports
  input  wire logic                 meterEnable,
  input  wire logic [1:0]           rateMode,
  input  wire logic                 cirWrite,
  input  wire logic [4:0]           cirIndex,
  input  wire logic [CIR_W-1:0]     cirData,
  input  wire logic [TOK_W-1:0]     committedBurst,
  input  wire logic [TOK_W-1:0]     excessBurst,
  // broadcast_throttle_config
  input  wire logic [2:0]           throttleEnable,
  input  wire logic [23:0]          throttleLevel,
  // flood_buffer_limit and buffer accounting from the buffer logic
  input  wire logic [BUF_W-1:0]     floodBufferLimit,
  input  wire logic [BUF_W-1:0]     floodBuffersUsed,
  // global_ingress_config
  input  wire logic                 groupSnoopEnable,
  input  wire logic                 listenerSnoopEnable,
  input  wire logic                 reflectToSnoop,
  input  wire logic [1:0]           snoopPort,
  input  wire logic                 vlanEnable,
  input  wire logic [5:0]           portStates,
  input  wire logic [2:0]           stateOverride,
  input  wire logic [2:0]           admitOnlyTagged,
  input  wire logic [2:0]           memberCheck,
  input  wire logic [2:0]           admitNonMember,
  input  wire logic [1:0]           priSelect,
  input  wire logic [8:0]           portDefaultPri,
  input  wire logic [191:0]         dsMap,
  // packet descriptor from the receive paths
  input  wire logic                 pktValid,
  output logic                      pktReady,
  input  wire logic [1:0]           pktPort,
  input  wire logic [11:0]          pktLength,
  input  wire logic                 pktBroadcast,
  input  wire logic                 pktFlood,
  input  wire logic                 pktIpv4,
  input  wire logic                 pktIpv6,
  input  wire logic [7:0]           pktProtocol,
  input  wire logic [7:0]           pktTos,
  input  wire logic                 pktTagged,
  input  wire logic [11:0]          pktVid,
  input  wire logic [2:0]           pktVlanPri,
  input  wire logic                 pktVlanMember,
  input  wire logic [2:0]           pktDestMask,
  // verdict towards forwarding
  output logic                      outValid,
  input  wire logic                 outReady,
  output sip_color_e                outColor,
  output logic                      outDrop,
  output logic                      outRandomDiscard,
  output logic                      outSnooped,
  output logic [2:0]                outDestMask
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  if (TOK_W < 13 || CIR_W < 4 || THROT_CYC < 1) begin : g_bad
    $error("sip_ingress_policer: unsupported parameter values");
  end

  localparam int NS = `SIP_NSTREAM;
  localparam int PW = TOK_W + 4;   // fractional byte-time accumulator width
  // the shortest byte time is below one clock period, so a cycle may owe two tokens
  localparam int MAX_TOK = 2;

  typedef struct packed {
    logic [NS-1:0][CIR_W-1:0] cir;
    logic [NS-1:0][TOK_W-1:0] cBucket;
    logic [NS-1:0][TOK_W-1:0] eBucket;
    logic [NS-1:0][PW-1:0]    tick;
    logic [21:0]              throtTimer;
    logic [2:0][17:0]         bcBytes;
    logic [1:0]               bufCount;
    logic [1:0][11:0]         bufFlags;
    logic [1:0][2:0]          bufDest;
    logic [1:0][1:0]          bufColor;
    logic                     bufWr;
    logic                     bufRd;
  } sip_state_s;

  sip_state_s st, next_st;

  // ---------------------------------------------------------------
  // helper functions
  // ---------------------------------------------------------------
  // byte time in ns for a rate setting: settings 0-3 clamp to the minimum
  function automatic logic [CIR_W+4:0] byteNs(input logic [CIR_W-1:0] s);
    logic [CIR_W-1:0] c;
    c = (s < CIR_W'(`SIP_CIR_MIN_SET)) ? CIR_W'(`SIP_CIR_MIN_SET) : s;
    byteNs = (CIR_W+5)'(c) * (CIR_W+5)'(`SIP_CIR_STEP_NS)
             + (CIR_W+5)'(`SIP_CIR_MIN_NS - `SIP_CIR_MIN_SET * `SIP_CIR_STEP_NS); // see RULE6
  endfunction

  function automatic logic [1:0] stpState(input logic [5:0] s, input logic [1:0] p);
    stpState = s[2*p +: 2];
  endfunction

  // ---------------------------------------------------------------
  // classification (combinational on the offered descriptor)
  // ---------------------------------------------------------------
  logic [2:0]  ingPri;
  logic [4:0]  streamIdx;
  logic        isGroup, isListen, snoop, snoopFilter;
  logic [TOK_W-1:0] len;

  always_comb begin
    unique case (priSelect) // see RULE11
      `SIP_PRISEL_PREC: ingPri = pktTos[7:5];
      `SIP_PRISEL_DS:   ingPri = dsMap[3*pktTos[7:2] +: 3]; // see RULE24
      `SIP_PRISEL_VLAN: ingPri = pktTagged ? pktVlanPri : portDefaultPri[3*pktPort +: 3];
      default:          ingPri = portDefaultPri[3*pktPort +: 3];
    endcase
    unique case (rateMode) // see RULE3
      `SIP_MODE_PORT: streamIdx = {3'h0, pktPort};
      `SIP_MODE_PRI:  streamIdx = {2'h0, ingPri};
      default:        streamIdx = {pktPort, ingPri}; // see RULE25
    endcase
    isGroup  = pktIpv4 && pktProtocol == `SIP_PROTO_GROUP;      // see RULE14
    isListen = pktIpv6 && pktProtocol == `SIP_NEXTHDR_LISTEN;  // see RULE15
    snoop    = (isGroup && groupSnoopEnable) || (isListen && listenerSnoopEnable); // see RULE16
    snoopFilter =
      (stpState(portStates, pktPort) != `SIP_STP_FORWARD && !stateOverride[pktPort]) // see RULE18 RULE23
      || (vlanEnable && (!pktTagged || pktVid == `SIP_VID_PRIO) && admitOnlyTagged[pktPort]) // see RULE19
      || (vlanEnable && pktTagged && pktVid == `SIP_VID_RESERVED)  // see RULE20
      || (vlanEnable && memberCheck[pktPort] && !admitNonMember[pktPort] && !pktVlanMember); // see RULE21
    len = TOK_W'(pktLength);
  end

  // ---------------------------------------------------------------
  // state update
  // ---------------------------------------------------------------
  logic accept;
  assign pktReady = st.bufCount != 2'h2;   // stall reaches the receive path
  assign accept   = pktValid && pktReady;

  always_comb begin
    logic [1:0]       col;
    logic             drop;
    logic [2:0]       dest;
    logic [2:0]       srcBit;
    logic [17:0]      allow;
    logic [1:0]       wr;
    logic [PW-1:0]    acc;
    logic [PW-1:0]    bt;
    acc = '0;
    bt = '0;
    next_st = st;
    col = SIP_NONE;
    drop = 1'b0;
    dest = 3'h0;
    srcBit = 3'h1 << pktPort;
    allow = 18'(throttleLevel[8*pktPort +: 8]) << `SIP_THROT_UNIT;
    wr = 2'h0;

    if (cirWrite && cirIndex < 5'(NS)) begin
      next_st.cir[cirIndex] = cirData; // see RULE4
    end

    // token fill at each stream's own byte time, one clock period per cycle
    for (int i = 0; i < NS; i++) begin
      acc = PW'(st.tick[i]) + PW'(`SIP_CLK_NS);
      bt  = PW'(byteNs(st.cir[i]));
      // one token per cycle would cap the fastest setting at the clock period
      for (int k = 0; k < MAX_TOK; k++) begin
        if (acc >= bt) begin
          acc = acc - bt; // see RULE6
          if (next_st.cBucket[i] < committedBurst) begin // see RULE5
            next_st.cBucket[i] = next_st.cBucket[i] + 1'b1;
          end else if (next_st.eBucket[i] < excessBurst) begin
            next_st.eBucket[i] = next_st.eBucket[i] + 1'b1;
          end
        end
      end
      // remainder stays below the longest byte time, even after a rate write, so the accumulator never wraps
      next_st.tick[i] = acc;
    end

    // broadcast window
    if (st.throtTimer >= 22'(THROT_CYC - 1)) begin // see RULE12
      next_st.throtTimer = 22'h0;
      next_st.bcBytes = '0;
    end else begin
      next_st.throtTimer = st.throtTimer + 22'h1;
    end

    if (accept) begin
      if (meterEnable) begin // see RULE2
        if (next_st.cBucket[streamIdx] >= len) begin // see RULE7 RULE1
          next_st.cBucket[streamIdx] = next_st.cBucket[streamIdx] - len;
          col = SIP_GREEN;
        end else if (next_st.eBucket[streamIdx] >= len) begin // see RULE8
          next_st.eBucket[streamIdx] = next_st.eBucket[streamIdx] - len;
          col = SIP_YELLOW;
        end else begin
          col = SIP_RED; // see RULE9
          drop = 1'b1;
        end
      end
      if (pktBroadcast && throttleEnable[pktPort]) begin
        if (next_st.bcBytes[pktPort] + 18'(pktLength) > allow) begin
          drop = 1'b1;
        end else begin
          next_st.bcBytes[pktPort] = next_st.bcBytes[pktPort] + 18'(pktLength);
        end
      end
      if (pktFlood && floodBuffersUsed >= floodBufferLimit) begin
        drop = 1'b1; // see RULE13
      end
      if (snoop) begin
        dest = 3'h1 << snoopPort; // see RULE16
        if (snoopFilter) begin
          drop = 1'b1;
        end
        if (!reflectToSnoop) begin
          dest = dest & ~srcBit; // see RULE17
        end
      end else begin
        dest = pktDestMask & ~srcBit; // see RULE17
      end
      next_st.bufFlags[st.bufWr] = {7'h0, drop, col == SIP_YELLOW, snoop, col};
      next_st.bufDest[st.bufWr]  = dest;
      next_st.bufColor[st.bufWr] = col;
      next_st.bufWr = ~st.bufWr;
      wr = 2'h1;
    end

    if (outValid && outReady) begin
      next_st.bufRd = ~st.bufRd;
      next_st.bufCount = st.bufCount + wr - 2'h1;
    end else begin
      next_st.bufCount = st.bufCount + wr;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      st <= '0;
      for (int i = 0; i < NS; i++) begin
        st.cBucket[i] <= TOK_W'(`SIP_BUCKET_INIT); // see RULE10
        st.eBucket[i] <= TOK_W'(`SIP_BUCKET_INIT);
      end
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // output side of the two-entry buffer
  // ---------------------------------------------------------------
  assign outValid         = st.bufCount != 2'h0;
  assign outColor         = sip_color_e'(st.bufColor[st.bufRd]);
  assign outDrop          = st.bufFlags[st.bufRd][4];
  assign outRandomDiscard = st.bufFlags[st.bufRd][3];
  assign outSnooped       = st.bufFlags[st.bufRd][2];
  assign outDestMask      = st.bufDest[st.bufRd];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  chk_red_drops: assert property (outValid && outColor == SIP_RED |-> outDrop) // see RULE9
    else $error("red packet not dropped");
  chk_yellow_random: assert property (outValid |-> outRandomDiscard == (outColor == SIP_YELLOW)) // see RULE8
    else $error("yellow mark mismatch");
  chk_no_meter_off: assert property (accept && !meterEnable |=> outColor == SIP_NONE || st.bufCount == 2'h2) // see RULE2
    else $error("colour given with metering off");
  chk_no_reflect: assert property (accept && !snoop && st.bufCount == 2'h0 |=>
      (outDestMask & (3'h1 << $past(pktPort))) == 3'h0) // see RULE17
    else $error("packet sent back to its source port");
  chk_snoop_dest: assert property (accept && snoop && st.bufCount == 2'h0 |=>
      outSnooped && (outDestMask & ~(3'h1 << snoopPort)) == 3'h0) // see RULE16
    else $error("snooped packet leaked");
  chk_reserved_vid: assert property (accept && snoop && vlanEnable && pktTagged
      && pktVid == `SIP_VID_RESERVED && st.bufCount == 2'h0 |=> outDrop) // see RULE20
    else $error("reserved vid not filtered");
  chk_flood_limit: assert property (accept && pktFlood && floodBuffersUsed >= floodBufferLimit
      && st.bufCount == 2'h0 |=> outDrop) // see RULE13
    else $error("flood limit ignored");
  chk_green_debit: assert property (accept && meterEnable && st.bufCount == 2'h0
      && st.cBucket[streamIdx] >= len |=> outColor == SIP_GREEN) // see RULE7
    else $error("green debit wrong");
  chk_state_filter: assert property (accept && snoop && st.bufCount == 2'h0
      && stpState(portStates, pktPort) != `SIP_STP_FORWARD && !stateOverride[pktPort] |=> outDrop) // see RULE18
    else $error("snooped packet from non-forwarding port kept");
  chk_untagged_filter: assert property (accept && snoop && st.bufCount == 2'h0 && vlanEnable
      && !pktTagged && admitOnlyTagged[pktPort] |=> outDrop) // see RULE19
    else $error("untagged snooped packet kept");
  chk_buffer_full: assert property (st.bufCount == 2'h2 |-> !pktReady && outValid)
    else $error("buffer handshake wrong");

  cov_green: cover property (outValid && outReady && outColor == SIP_GREEN);
  cov_yellow: cover property (outValid && outReady && outColor == SIP_YELLOW);
  cov_red: cover property (outValid && outReady && outColor == SIP_RED);
  cov_snoop: cover property (outValid && outReady && outSnooped);
  cov_full: cover property (st.bufCount == 2'h2 && pktValid);

endmodule

//--- testbench/sip_fwd_sink.sv
// forwarding-side model: accepts verdicts and can stall
`timescale 1ns/1ns
module sip_fwd_sink
  import sip_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       stall,
  input  wire logic       outValid,
  output logic            outReady,
  input  wire sip_color_e outColor,
  input  wire logic       outDrop,
  input  wire logic       outRandomDiscard,
  input  wire logic       outSnooped,
  input  wire logic [2:0] outDestMask
);
  logic       stallSeen;
  logic [7:0] got[$];
  // ready moves on the falling edge so the sampling edge never races it
  always @(posedge clk) stallSeen <= stall;
  // the verdict is settled at the falling edge and is taken at the next rising edge
  // host software would learn the group from snooped verdicts and forward the original
  always @(negedge clk) begin
    outReady <= !stallSeen;
    if (outValid && !stallSeen) begin
      got.push_back({outColor, outDrop, outRandomDiscard, outSnooped, outDestMask});
    end
  end
endmodule

//--- testbench/sip_ingress_policer_tb.sv
// self-checking bench for the ingress policing and snoop stage
`timescale 1ns/1ns
`include "sip_defs.svh"
module sip_ingress_policer_tb
  import sip_pkg::*;
;
  logic         clk, resetn, meterEnable, cirWrite, groupSnoopEnable, listenerSnoopEnable;
  logic         reflectToSnoop, vlanEnable, pktValid, pktReady, pktBroadcast, pktFlood, pktIpv4;
  logic         pktIpv6, pktTagged, pktVlanMember, outValid, outReady, outDrop, outRandomDiscard;
  logic         outSnooped, stall;
  logic [1:0]   rateMode, snoopPort, priSelect, pktPort;
  logic [2:0]   throttleEnable, stateOverride, admitOnlyTagged, memberCheck, admitNonMember;
  logic [2:0]   pktVlanPri, pktDestMask, outDestMask;
  logic [4:0]   cirIndex;
  logic [5:0]   portStates;
  logic [7:0]   pktProtocol, pktTos;
  logic [8:0]   portDefaultPri;
  logic [9:0]   floodBufferLimit, floodBuffersUsed;
  logic [11:0]  pktLength, pktVid;
  logic [13:0]  cirData;
  logic [16:0]  committedBurst, excessBurst;
  logic [23:0]  throttleLevel;
  logic [191:0] dsMap;
  sip_color_e   outColor;
  int           num_errors, total_checks, cycles, waits;

  // window shortened so the refill is seen within the run
  sip_ingress_policer #(.THROT_CYC(1000)) dut_u (.*);
  sip_fwd_sink sink_u (.*);

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  task automatic defaults();
    {meterEnable, cirWrite, groupSnoopEnable, listenerSnoopEnable, reflectToSnoop, vlanEnable} = '0;
    {pktValid, pktBroadcast, pktFlood, pktIpv4, pktIpv6, pktTagged, stall, rateMode, snoopPort} = '0;
    {priSelect, pktPort, throttleEnable, stateOverride, admitOnlyTagged, memberCheck} = '0;
    {admitNonMember, pktVlanPri, cirIndex, portStates, pktProtocol, pktTos, portDefaultPri} = '0;
    {floodBuffersUsed, pktLength, pktVid, cirData, dsMap} = '0;
    {committedBurst, excessBurst} = {2{`SIP_BUCKET_INIT}};
    {pktVlanMember, pktDestMask, throttleLevel, floodBufferLimit} = {1'b1, 3'h7, 24'hFFFFFF, 10'h3FF};
  endtask

  task automatic wr_cir(input logic [4:0] idx, input logic [13:0] val);
    cirIndex = idx;
    cirData  = val;
    cirWrite = 1'b1;
    @(negedge clk);
    cirWrite = 1'b0;
    @(negedge clk);
  endtask

  // every stream is made slow so that refill stays out of the way
  task automatic reset_dut();
    @(negedge clk);
    defaults();
    resetn = 1'b0;
    repeat (5) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 24; i++) wr_cir(5'(i), 14'h3FFF);
  endtask

  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // a verdict packs colour, drop, random discard, snooped and destination mask
  task automatic chk(input logic [7:0] e, input logic [7:0] m);
    logic [7:0] v;
    v = 8'hXX;
    repeat (40) if (sink_u.got.size() == 0) @(negedge clk);
    if (sink_u.got.size() != 0) v = sink_u.got.pop_front();
    cmp(v & m, e & m);
  endtask

  // leaves valid high so that a following send is back-to-back
  task automatic send(input logic [1:0] p, input logic [11:0] len, input logic [7:0] pr = 8'h00,
                      input logic [1:0] fam = 2'h0, input logic [11:0] vid = 12'h000,
                      input logic [1:0] kind = 2'h0);
    @(negedge clk);
    {pktPort, pktLength, pktProtocol, pktIpv6, pktIpv4, pktVid, pktFlood, pktBroadcast} =
      {p, len, pr, fam, vid, kind};
    pktTagged = (vid != 12'h000);
    pktValid  = 1'b1;
    waits     = 0;
    while (!pktReady) begin
      waits++;
      @(negedge clk);
    end
    @(posedge clk);
  endtask

  task automatic run(input logic [1:0] p, input logic [11:0] len, input logic [7:0] e, input logic [7:0] m,
                     input logic [7:0] pr = 8'h00, input logic [1:0] fam = 2'h0,
                     input logic [11:0] vid = 12'h005, input logic [1:0] kind = 2'h0);
    send(p, len, pr, fam, vid, kind);
    @(negedge clk);
    pktValid = 1'b0;
    chk(e, m);
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    defaults();
    resetn = 1'b0;
    reset_dut();
    cmp({6'h00, outValid, pktReady}, 8'h01);
    meterEnable    = 1'b1;
    committedBurst = 17'h00064;
    excessBurst    = 17'h00064;
    stall          = 1'b1;
    send(2'h0, 12'h3E8);
    send(2'h0, 12'h3E8);
    fork
      send(2'h0, 12'h3E8);
      begin
        repeat (4) @(negedge clk);
        stall = 1'b0;
      end
    join
    cmp(8'(waits > 1), 8'h01);
    send(2'h1, 12'h3E8);
    @(negedge clk);
    pktValid = 1'b0;
    chk(8'h00, 8'hF8);
    chk(8'h50, 8'hF8);
    chk(8'hA0, 8'hF8);
    chk(8'h00, 8'hF8);
    $display("per-port meter test done");
    reset_dut();
    meterEnable = 1'b1;
    wr_cir(5'h00, 14'h0003);
    run(2'h0, 12'h3E8, 8'h00, 8'hF8);
    repeat (300) @(negedge clk);
    run(2'h0, 12'h3E8, 8'h50, 8'hF8);
    repeat (900) @(negedge clk);
    run(2'h0, 12'h5DC, 8'h00, 8'hF8);
    run(2'h1, 12'h5DC, 8'h00, 8'hF8);
    run(2'h1, 12'h3E8, 8'h50, 8'hF8);
    $display("refill test done");
    reset_dut();
    meterEnable    = 1'b1;
    rateMode       = `SIP_MODE_PRI;
    pktVlanPri     = 3'h5;
    portDefaultPri = 9'h028;
    dsMap[17:15]   = 3'h5;
    priSelect      = `SIP_PRISEL_VLAN;
    run(2'h0, 12'h3E8, 8'h00, 8'hF8);
    priSelect = 2'h3;
    run(2'h1, 12'h3E8, 8'h50, 8'hF8, 8'h00, 2'h0, 12'h000);
    pktTos    = 8'h14;
    priSelect = `SIP_PRISEL_DS;
    run(2'h2, 12'h3E8, 8'hA0, 8'hF8, 8'h00, 2'h1);
    pktTos    = 8'hA4;
    priSelect = `SIP_PRISEL_PREC;
    run(2'h0, 12'h3E8, 8'hA0, 8'hF8, 8'h00, 2'h1);
    rateMode       = 2'h2;
    priSelect      = 2'h3;
    portDefaultPri = 9'h02D;
    run(2'h0, 12'h3E8, 8'hA0, 8'hF8);
    run(2'h1, 12'h3E8, 8'h00, 8'hF8);
    $display("priority stream test done");
    reset_dut();
    run(2'h0, 12'hFA0, 8'hC0, 8'hF8);
    throttleEnable = 3'h2;
    throttleLevel  = 24'h000100;
    repeat (1100) @(negedge clk);
    run(2'h1, 12'h040, 8'hC0, 8'hF8, 8'h00, 2'h0, 12'h000, 2'h1);
    run(2'h1, 12'h001, 8'hE0, 8'hF8, 8'h00, 2'h0, 12'h000, 2'h1);
    run(2'h0, 12'h0C8, 8'hC0, 8'hF8, 8'h00, 2'h0, 12'h000, 2'h1);
    repeat (1100) @(negedge clk);
    run(2'h1, 12'h040, 8'hC0, 8'hF8, 8'h00, 2'h0, 12'h000, 2'h1);
    floodBufferLimit = 10'h004;
    floodBuffersUsed = 10'h004;
    run(2'h2, 12'h040, 8'hE0, 8'hF8, 8'h00, 2'h0, 12'h000, 2'h2);
    floodBuffersUsed = 10'h003;
    run(2'h2, 12'h040, 8'hC0, 8'hF8, 8'h00, 2'h0, 12'h000, 2'h2);
    $display("throttle and flood test done");
    groupSnoopEnable = 1'b1;
    pktDestMask      = 3'h6;
    run(2'h1, 12'h040, 8'hC9, 8'hFF, 8'h02, 2'h1);
    run(2'h1, 12'h040, 8'hC4, 8'hFF, 8'h03, 2'h1);
    run(2'h1, 12'h040, 8'hC4, 8'hFF, 8'h02, 2'h2);
    groupSnoopEnable    = 1'b0;
    listenerSnoopEnable = 1'b1;
    run(2'h2, 12'h040, 8'hC9, 8'hFF, 8'h3A, 2'h2);
    run(2'h2, 12'h040, 8'hC2, 8'hFF, 8'h02, 2'h1);
    snoopPort = 2'h2;
    run(2'h2, 12'h040, 8'h00, 8'h07, 8'h3A, 2'h2);
    reflectToSnoop = 1'b1;
    run(2'h2, 12'h040, 8'h0C, 8'h0F, 8'h3A, 2'h2);
    snoopPort  = 2'h0;
    vlanEnable = 1'b1;
    portStates = 6'h04;
    run(2'h1, 12'h040, 8'h20, 8'h20, 8'h3A, 2'h2);
    stateOverride = 3'h2;
    run(2'h1, 12'h040, 8'h00, 8'h20, 8'h3A, 2'h2);
    portStates      = 6'h00;
    stateOverride   = 3'h0;
    admitOnlyTagged = 3'h2;
    run(2'h1, 12'h040, 8'h20, 8'h20, 8'h3A, 2'h2, 12'h000);
    run(2'h1, 12'h040, 8'h00, 8'h20, 8'h3A, 2'h2);
    run(2'h1, 12'h040, 8'h20, 8'h20, 8'h3A, 2'h2, 12'hFFF);
    memberCheck   = 3'h2;
    pktVlanMember = 1'b0;
    run(2'h1, 12'h040, 8'h20, 8'h20, 8'h3A, 2'h2);
    admitNonMember = 3'h2;
    run(2'h1, 12'h040, 8'h00, 8'h20, 8'h3A, 2'h2);
    $display("snoop test done");
    complete_run();
  end
endmodule
